// ---- design/nvm_unlock_erase_eeprom_write.v ----
// Function
// - Keys 55h then AAh then start bit, in that order, before any operation.
// - Sequence tracking begins at the first unlock key register write.
// - EEPROM write stores one data byte after an automatic byte erase.
// - EEPROM write runs in the background without stalling the CPU.
// - EEPROM done clears start, sets done flag, may interrupt, keeps enable.
// - Software clearing start during an EEPROM write is ignored.
// - Flash erased only by whole rows; writes never erase.
// - Row erase hits flash with region clear, user IDs when set.
// - Protected flash row: clear start, no erase.
// - Flash row erase stalls CPU, then sets done flag and may interrupt.
// - Row erase leaves write latches and write enable untouched.
// - Broken unlock sequence loads no latch and starts nothing.
// - Code protection blocks all register-driven reads, writes and erases.
// - A row is 32 words of 14 bits; erase clears them all.
// - Upper ten address bits pick the row, lower five the word.
`timescale 1ns/100ps
`include "nvm_seq_map.vh"
module nvm_unlock_erase_eeprom_write #(
    parameter EE_WRITE_NS  = `EE_WRITE_NS,
    parameter ROW_ERASE_NS = `ROW_ERASE_NS,
    parameter ROW_WORDS    = `ROW_WORDS
) (
    input  wire        i_clk,
    input  wire        i_rst_b,
    input  wire [2:0]  i_addr,
    input  wire [7:0]  i_wdata,
    input  wire        i_wr,
    input  wire        i_rd,
    output reg  [7:0]  o_rdata,
    input  wire        i_code_protect,
    input  wire [9:0]  i_protect_rows,
    output reg         o_mem_wr,
    output reg         o_mem_region,
    output reg  [14:0] o_mem_addr,
    output reg  [13:0] o_mem_wdata,
    output wire        o_cpu_stall,
    output wire        o_busy,
    output wire        o_irq_req
);

    // Wait counts round up, never short of the stated time
    localparam EE_CYC  = (EE_WRITE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
    localparam ROW_CYC = (ROW_ERASE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;

    localparam K_IDLE = 2'b00;
    localparam K_55   = 2'b01;
    localparam K_AA   = 2'b10;

    localparam S_IDLE = 2'b00;
    localparam S_EE   = 2'b01;
    localparam S_ROW  = 2'b10;
    localparam S_HOLD = 2'b11;

    reg  [1:0]  key_state;
    reg  [1:0]  state;
    reg         write_enable_bit;
    reg         latch_only_bit;
    reg         erase_sel_bit;
    reg         region_select_bit;
    reg  [7:0]  addr_lo;
    reg  [6:0]  addr_hi;
    reg  [7:0]  write_data_reg;
    reg         memory_done_flag;
    reg         done_irq_enable;
    reg  [31:0] wait_cnt;
    reg  [4:0]  word_idx;
    reg         op_region;
    reg  [9:0]  op_row;
    reg  [7:0]  op_byte;
    reg  [7:0]  op_data;
    reg  [5:0]  words_left;
    reg  [7:0]  next_rdata;

    wire [14:0] target_address_pair = {addr_hi, addr_lo};
    wire        ctrl_wr   = i_wr && (i_addr == `OFS_CTRL);
    wire        key_wr    = i_wr && (i_addr == `OFS_KEY);
    wire        start_req = ctrl_wr && i_wdata[`CTRL_START];
    wire        idle      = (state == S_IDLE);
    // Launch only straight after the two keys
    wire        unlocked  = start_req && (key_state == K_AA) && idle;
    // region, erase bit and EEPROM page pick the byte path
    wire        ee_ok     = region_select_bit && !erase_sel_bit
                            && (addr_hi == `EE_PAGE);
    wire        row_prot  = !region_select_bit
                            && (target_address_pair[14:5] < i_protect_rows);
    wire        uid_ok    = !region_select_bit
                            || (target_address_pair <= `UID_LAST);
    wire        done_set;

    wire        launch_ok;
    wire        launch_ee;
    wire        launch_row;
    wire        row_emit;

    // Control bits are the ones held before the start write
    // nothing starts without the full sequence
    assign launch_ok  = unlocked && write_enable_bit && !i_code_protect
                        && !latch_only_bit;
    assign launch_ee  = launch_ok && ee_ok;
    // only explicit row erases clear flash
    assign launch_row = launch_ok && !ee_ok && erase_sel_bit && !row_prot && uid_ok;
    // one erase pulse per remaining word
    assign row_emit   = (state == S_ROW) && (words_left != 6'h00);

    // key tracking starts on the key register
    // any other access drops the sequence
    always @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            key_state <= K_IDLE;
        end else if (i_wr || i_rd) begin
            case (key_state)
                K_IDLE: begin
                    if (key_wr && i_wdata == `KEY_FIRST) begin
                        key_state <= K_55;
                    end
                end
                // A fresh 55h restarts the count
                K_55: begin
                    if (key_wr && i_wdata == `KEY_SECOND) begin
                        key_state <= K_AA;
                    end else if (key_wr && i_wdata == `KEY_FIRST) begin
                        key_state <= K_55;
                    end else begin
                        key_state <= K_IDLE;
                    end
                end
                K_AA: begin
                    // start bit is the last step
                    key_state <= (key_wr && i_wdata == `KEY_FIRST) ? K_55 : K_IDLE;
                end
                default: begin
                    key_state <= K_IDLE;
                end
            endcase
        end
    end

    // Software-visible control and data registers
    always @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            write_enable_bit  <= 1'b0;
            latch_only_bit    <= 1'b0;
            erase_sel_bit     <= 1'b0;
            region_select_bit <= 1'b0;
            addr_lo           <= 8'h00;
            addr_hi           <= 7'h00;
            write_data_reg    <= 8'h00;
            done_irq_enable   <= 1'b0;
        end else if (i_wr) begin
            case (i_addr)
                // enable bit only changes by software
                `OFS_CTRL: begin
                    write_enable_bit  <= i_wdata[`CTRL_WRITE_ENABLE_BIT];
                    latch_only_bit    <= i_wdata[`CTRL_LATCH];
                    erase_sel_bit     <= i_wdata[`CTRL_ERASE];
                    region_select_bit <= i_wdata[`CTRL_REGION];
                end
                `OFS_ADDR_LO: begin
                    addr_lo <= i_wdata;
                end
                `OFS_ADDR_HI: begin
                    addr_hi <= i_wdata[6:0];
                end
                `OFS_DATA: begin
                    write_data_reg <= i_wdata;
                end
                `OFS_STATUS: begin
                    done_irq_enable <= i_wdata[`STAT_IRQ_EN];
                end
                default: begin
                    write_data_reg <= write_data_reg;
                end
            endcase
        end
    end

    // Done flag: hardware set beats a write-one clear
    // set on completion
    always @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            memory_done_flag <= 1'b0;
        end else if (done_set) begin
            memory_done_flag <= 1'b1;
        end else if (i_wr && i_addr == `OFS_STATUS && i_wdata[`STAT_DONE]) begin
            memory_done_flag <= 1'b0;
        end
    end

    assign done_set = (state == S_HOLD);

    // word count kept apart from erase time
    // A short erase time would otherwise drop the tail of the row
    always @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            words_left <= 6'h00;
        end else if (launch_row) begin
            words_left <= ROW_WORDS[5:0];
        end else if (row_emit) begin
            words_left <= words_left - 6'h01;
        end
    end

    // Operation sequencer
    always @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            state        <= S_IDLE;
            wait_cnt     <= 32'h00000000;
            word_idx     <= 5'h00;
            op_region    <= 1'b0;
            op_row       <= 10'h000;
            op_byte      <= 8'h00;
            op_data      <= 8'h00;
            o_mem_wr     <= 1'b0;
            o_mem_region <= 1'b0;
            o_mem_addr   <= 15'h0000;
            o_mem_wdata  <= 14'h0000;
        end else begin
            o_mem_wr <= 1'b0;
            case (state)
                S_IDLE: begin
                    if (launch_ok) begin
                        op_region <= region_select_bit;
                        op_row    <= target_address_pair[14:5];
                        op_byte   <= addr_lo;
                        op_data   <= write_data_reg;
                        word_idx  <= 5'h00;
                        if (launch_ee) begin
                            state        <= S_EE;
                            wait_cnt     <= EE_CYC[31:0];
                            o_mem_wr     <= 1'b1;
                            o_mem_region <= 1'b1;
                            o_mem_addr   <= target_address_pair;
                            o_mem_wdata  <= `ERASED_BYTE;
                        end else if (launch_row) begin
                            state    <= S_ROW;
                            wait_cnt <= ROW_CYC[31:0];
                        end
                    end
                end
                S_EE: begin
                    if (wait_cnt > 32'h00000001) begin
                        wait_cnt <= wait_cnt - 32'h00000001;
                    end else begin
                        o_mem_wr    <= 1'b1;
                        o_mem_region <= 1'b1;
                        o_mem_addr  <= {`EE_PAGE, op_byte};
                        o_mem_wdata <= {6'h00, op_data};
                        state       <= S_HOLD;
                    end
                end
                // region picks flash or user IDs
                // all words of the row are blanked
                // row from upper ten bits, word from lower five
                S_ROW: begin
                    if (row_emit) begin
                        o_mem_wr     <= 1'b1;
                        o_mem_region <= op_region;
                        o_mem_addr   <= {op_row, word_idx};
                        o_mem_wdata  <= `ERASED_WORD;
                        word_idx     <= word_idx + 5'h01;
                    end
                    if (wait_cnt > 32'h00000001) begin
                        wait_cnt <= wait_cnt - 32'h00000001;
                    end else if (words_left < 6'h02) begin
                        state <= S_HOLD;
                    end
                end
                S_HOLD: begin
                    state <= S_IDLE;
                end
                default: begin
                    state <= S_IDLE;
                end
            endcase
        end
    end

    // CPU held for the whole row erase
    assign o_cpu_stall = (state == S_ROW);
    assign o_busy      = !idle;
    // interrupt request gated by the enable
    assign o_irq_req   = memory_done_flag && done_irq_enable;

    // Read mux; the flop below gives data one cycle after the strobe
    always @* begin
        next_rdata = 8'h00;
        if (i_rd) begin
            case (i_addr)
                `OFS_CTRL: begin
                    next_rdata = {2'b00, region_select_bit, erase_sel_bit,
                                  latch_only_bit, write_enable_bit, o_busy, 1'b0};
                end
                // Keys are write only
                `OFS_KEY: begin
                    next_rdata = 8'h00;
                end
                `OFS_ADDR_LO: begin
                    next_rdata = addr_lo;
                end
                `OFS_ADDR_HI: begin
                    next_rdata = {1'b0, addr_hi};
                end
                `OFS_DATA: begin
                    next_rdata = i_code_protect ? 8'h00 : write_data_reg;
                end
                `OFS_STATUS: begin
                    next_rdata = {6'h00, done_irq_enable, memory_done_flag};
                end
                default: begin
                    next_rdata = 8'h00;
                end
            endcase
        end
    end

    // Zero outside the cycle after a read strobe
    always @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_rdata <= 8'h00;
        end else begin
            o_rdata <= next_rdata;
        end
    end

endmodule

// ---- design/nvm_seq_map.vh ----
`ifndef NVM_SEQ_MAP_VH
`define NVM_SEQ_MAP_VH

// Register offsets
`define OFS_CTRL        3'h0
`define OFS_KEY         3'h1
`define OFS_ADDR_LO     3'h2
`define OFS_ADDR_HI     3'h3
`define OFS_DATA        3'h4
`define OFS_STATUS      3'h5

// Control register fields
`define CTRL_START      1
`define CTRL_WRITE_ENABLE_BIT       2
`define CTRL_LATCH      3
`define CTRL_ERASE      4
`define CTRL_REGION     5

// Status register fields
`define STAT_DONE       0
`define STAT_IRQ_EN     1

// Unlock keys
`define KEY_FIRST       8'h55
`define KEY_SECOND      8'hAA

// EEPROM window in the upper address byte
`define EE_PAGE         7'h70
// User ID locations in the configuration region
`define UID_LAST        15'h0003

// Row geometry
`define ROW_WORDS       32
`define WORD_BITS       14
`define ERASED_WORD     14'h3FFF
`define ERASED_BYTE     14'h00FF

// Timing
`define CLK_PERIOD_NS   10
`define EE_WRITE_NS     4000000
`define ROW_ERASE_NS    2000000

`endif

// ---- tb/nvm_seq_checker.sv ----
`timescale 1ns/100ps
`include "nvm_seq_map.vh"
module nvm_seq_checker (
    input wire        i_clk,
    input wire        i_rst_b,
    input wire [2:0]  i_addr,
    input wire [7:0]  i_wdata,
    input wire        i_wr,
    input wire        i_rd,
    input wire        i_code_protect,
    input wire [7:0]  o_rdata,
    input wire        o_mem_wr,
    input wire [14:0] o_mem_addr,
    input wire [13:0] o_mem_wdata,
    input wire        o_cpu_stall,
    input wire        o_busy
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_b);
    sequence s_first_word;
        o_mem_wr && o_mem_addr[4:0] == 5'h00;
    endsequence
    sequence s_key_pair;
        $past(i_wr && i_addr == `OFS_KEY && i_wdata == `KEY_FIRST, 3) &&
        $past(i_wr && i_addr == `OFS_KEY && i_wdata == `KEY_SECOND, 2);
    endsequence
    a_rdata_idle: assert property (
        !$past(i_rd) |-> o_rdata == 8'h00) else $error("stray read data");
    a_launch_keys: assert property (
        $rose(o_busy) |-> s_key_pair and
        $past(i_wr && i_addr == `OFS_CTRL && i_wdata[`CTRL_START]))
        else $error("launch without unlock");
    a_launch_unprot: assert property (
        $rose(o_busy) |-> !$past(i_code_protect)) else $error("launch while protected");
    a_stall_busy: assert property (
        o_cpu_stall |-> o_busy) else $error("stall while idle");
    a_row_erased: assert property (
        o_mem_wr && o_cpu_stall |-> o_mem_wdata == `ERASED_WORD) else $error("row word not blank");
    a_first_word: assert property (
        $rose(o_cpu_stall) |=> s_first_word) else $error("row erase not from word 0");
    a_word_step: assert property (
        o_mem_wr && o_cpu_stall && o_mem_addr[4:0] != 5'h1F |=>
        o_mem_wr && o_mem_addr == $past(o_mem_addr) + 15'h0001) else $error("row word skipped");
    a_ee_erase_first: assert property (
        $rose(o_busy) && !o_cpu_stall |-> o_mem_wr && o_mem_wdata == `ERASED_BYTE &&
        o_mem_addr[14:8] == `EE_PAGE) else $error("byte erase missing");
endmodule
bind nvm_unlock_erase_eeprom_write nvm_seq_checker nvm_seq_checker_i (
    .i_clk(i_clk), .i_rst_b(i_rst_b), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .i_code_protect(i_code_protect), .o_rdata(o_rdata),
    .o_mem_wr(o_mem_wr), .o_mem_addr(o_mem_addr), .o_mem_wdata(o_mem_wdata),
    .o_cpu_stall(o_cpu_stall), .o_busy(o_busy));

// ---- tb/nvm_mem_model.sv ----
`timescale 1ns/100ps
module nvm_mem_model (
    input  wire        i_clk,
    input  wire        i_mem_wr,
    input  wire        i_mem_region,
    input  wire [14:0] i_mem_addr,
    input  wire [13:0] i_mem_wdata,
    output reg  [15:0] o_count,
    output reg         o_region,
    output reg  [14:0] o_addr,
    output reg  [13:0] o_data
);
    // Running count, so a short row erase shows up
    initial o_count = 16'h0000;
    always @(posedge i_clk) begin
        if (i_mem_wr) begin
            o_count <= o_count + 16'h0001;
            o_region <= i_mem_region;
            o_addr <= i_mem_addr;
            o_data <= i_mem_wdata;
        end
    end
endmodule

// ---- tb/nvm_unlock_erase_eeprom_write_bench.sv ----
`timescale 1ns/100ps
`include "nvm_seq_map.vh"
module nvm_unlock_erase_eeprom_write_bench;
    reg         i_clk, i_rst_b, i_wr, i_rd, i_code_protect;
    reg  [2:0]  i_addr;
    reg  [7:0]  i_wdata;
    wire [7:0]  o_rdata;
    wire        o_mem_wr, o_mem_region, o_cpu_stall, o_busy, o_irq_req, m_region;
    wire [14:0] o_mem_addr, m_addr;
    wire [13:0] o_mem_wdata, m_data;
    wire [15:0] m_count;
    reg  [15:0] base;
    int         n_fail;
    int         samples_checked;
    // Short timings keep the run brief: 50 and 60 cycles
    nvm_unlock_erase_eeprom_write #(.EE_WRITE_NS(500), .ROW_ERASE_NS(600))
    nvm_unlock_erase_eeprom_write_i (
        .i_clk(i_clk), .i_rst_b(i_rst_b), .i_addr(i_addr), .i_wdata(i_wdata),
        .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_code_protect(i_code_protect),
        .i_protect_rows(10'h002), .o_mem_wr(o_mem_wr), .o_mem_region(o_mem_region),
        .o_mem_addr(o_mem_addr), .o_mem_wdata(o_mem_wdata), .o_cpu_stall(o_cpu_stall),
        .o_busy(o_busy), .o_irq_req(o_irq_req));
    nvm_mem_model nvm_mem_model_i (
        .i_clk(i_clk), .i_mem_wr(o_mem_wr), .i_mem_region(o_mem_region),
        .i_mem_addr(o_mem_addr), .i_mem_wdata(o_mem_wdata), .o_count(m_count),
        .o_region(m_region), .o_addr(m_addr), .o_data(m_data));
    task results;
        if (n_fail == 0 && samples_checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task chk(input bit ok, input int id);
        samples_checked++;
        if (!ok) begin
            n_fail++;
            $display("[FAIL] %0t check %0d", $time, id);
        end
    endtask
    // Strobes are left up; the next task or gap lowers them
    task wr(input [2:0] a, input [7:0] d);
        i_addr <= a;
        i_wdata <= d;
        i_wr <= 1'b1;
        i_rd <= 1'b0;
        @(posedge i_clk);
        #1;
    endtask
    task rd(input [2:0] a, input [7:0] e, input int id);
        i_addr <= a;
        i_wr <= 1'b0;
        i_rd <= 1'b1;
        @(posedge i_clk);
        #1;
        chk(o_rdata === e, id);
    endtask
    task gap(input int n);
        i_wr <= 1'b0;
        i_rd <= 1'b0;
        repeat (n) @(posedge i_clk);
        #1;
    endtask
    // Back to back with nothing between, as masked interrupts give
    task unlock(input [7:0] c);
        wr(`OFS_KEY, `KEY_FIRST);
        wr(`OFS_KEY, `KEY_SECOND);
        wr(`OFS_CTRL, c | 8'h02);
    endtask
    task wait_idle;
        int k;
        k = 0;
        gap(1);
        while (o_busy !== 1'b0 && k < 300) begin
            gap(1);
            k++;
        end
        if (k == 300) begin
            n_fail++;
            $display("[FAIL] %0t busy timeout", $time);
            results;
        end
    endtask
    task refuse(input [7:0] c, input [7:0] lo, input bit prot);
        i_code_protect <= prot;
        base = m_count;
        wr(`OFS_ADDR_LO, lo);
        wr(`OFS_CTRL, c);
        unlock(c);
        gap(3);
        chk(o_busy === 1'b0 && m_count === base, c);
        i_code_protect <= 1'b0;
    endtask
    initial begin
        i_clk = 1'b0;
        forever #5 i_clk = ~i_clk;
    end
    initial begin
        n_fail = 0;
        samples_checked = 0;
        {i_rst_b, i_wr, i_rd, i_code_protect, i_addr, i_wdata} = 0;
        repeat (8) @(posedge i_clk);
        i_rst_b <= 1'b1;
        gap(1);
        rd(`OFS_CTRL, 8'h00, 1);
        rd(`OFS_STATUS, 8'h00, 2);
        rd(`OFS_KEY, 8'h00, 3);
        rd(3'h6, 8'h00, 4);
        wr(`OFS_CTRL, 8'h24);
        wr(`OFS_ADDR_HI, 8'h70);
        wr(`OFS_ADDR_LO, 8'h12);
        wr(`OFS_DATA, 8'h5A);
        wr(`OFS_STATUS, 8'h02);
        unlock(8'h24);
        wr(`OFS_CTRL, 8'h24);
        gap(1);
        chk(o_busy === 1'b1 && o_cpu_stall === 1'b0, 5);
        wait_idle;
        chk(m_count === 16'h0002 && m_addr === 15'h7012 && m_data === 14'h005A, 6);
        chk(m_region === 1'b1 && o_irq_req === 1'b1, 7);
        rd(`OFS_CTRL, 8'h24, 8);
        rd(`OFS_STATUS, 8'h03, 9);
        wr(`OFS_STATUS, 8'h03);
        rd(`OFS_STATUS, 8'h02, 10);
        chk(o_irq_req === 1'b0, 11);
        wr(`OFS_ADDR_HI, 8'h00);
        wr(`OFS_ADDR_LO, 8'hA7);
        wr(`OFS_CTRL, 8'h14);
        unlock(8'h14);
        gap(1);
        chk(o_cpu_stall === 1'b1, 12);
        wait_idle;
        chk(m_count === 16'h0022 && m_addr === 15'h00BF && m_region === 1'b0, 13);
        chk(m_data === `ERASED_WORD, 14);
        rd(`OFS_CTRL, 8'h14, 15);
        rd(`OFS_STATUS, 8'h03, 16);
        wr(`OFS_STATUS, 8'h01);
        refuse(8'h10, 8'hA0, 1'b0);
        refuse(8'h14, 8'h20, 1'b0);
        refuse(8'h14, 8'hA0, 1'b1);
        base = m_count;
        wr(`OFS_KEY, `KEY_FIRST);
        rd(`OFS_STATUS, 8'h00, 17);
        wr(`OFS_KEY, `KEY_SECOND);
        wr(`OFS_CTRL, 8'h16);
        gap(3);
        chk(o_busy === 1'b0 && m_count === base, 18);
        wr(`OFS_ADDR_LO, 8'h02);
        wr(`OFS_CTRL, 8'h34);
        unlock(8'h34);
        wait_idle;
        chk(m_count === base + 16'h0020 && m_region === 1'b1, 19);
        results;
    end
endmodule
